// ==== verilog/stepper_front.sv ====
// Stepper front end: serial command port, step/direction counter, sine table, coil target mux.
// Assumes a 125 MHz core clock and a serial bus clock from the master on its own port.
`timescale 1ns/1ns
`default_nettype none
`include "stepper_cfg.svh"
module stepper_front
	import stepper_pkg::*;
#(
	parameter int GLITCH_CYC = `GLITCH_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       bus_clk,
	input  wire logic       chip_select_low,
	input  wire logic       sdi,
	output logic            sdo,
	input  wire logic       step_in,
	input  wire logic       dir_in,
	input  wire logic       output_stage_enable_low,
	output coil_t           coil_target,
	output logic            bridge_on,
	output logic            chop_hyst,
	output logic [9:0]      ustep_pos
);
	initial begin
		if (GLITCH_CYC < 1 || GLITCH_CYC > 255) begin
			$error("GLITCH_CYC out of range");
		end
	end

	// Link domain. The frame ends on chip select, since the bus clock stops between frames.
	logic [19:0] shin_q, shin_d;
	logic [19:0] shout_q, shout_d;
	logic [4:0]  bcnt_q, bcnt_d;
	logic [19:0] stat_cap_q;
	logic [19:0] frame_q;
	logic        frame_tog_q;
	logic [19:0] status_word;

	// Status is taken once as chip select falls, so the reply shows the state at frame start.
	// The bus clock stands still between frames, so it cannot carry a fresh copy over.
	// Limitation: a step landing in the same few nanoseconds may give a mixed position.
	always_ff @(negedge chip_select_low) begin
		stat_cap_q <= status_word;
	end

	always_comb begin
		shin_d  = {shin_q[18:0], sdi};
		bcnt_d  = (bcnt_q == 5'h1f) ? bcnt_q : bcnt_q + 5'd1;
		shout_d = (bcnt_q == 5'd0) ? {stat_cap_q[18:0], 1'b0} : {shout_q[18:0], 1'b0};
	end

	always_ff @(posedge bus_clk or posedge chip_select_low) begin
		if (chip_select_low) begin
			shin_q  <= 20'h00000;
			bcnt_q  <= 5'd0;
			shout_q <= 20'h00000;
		end else begin
			shin_q  <= shin_d;
			bcnt_q  <= bcnt_d;
			shout_q <= shout_d;
		end
	end

	always_comb begin
		sdo = (bcnt_q == 5'd0) ? stat_cap_q[19] : shout_q[19];
	end

	// A frame counts only when exactly twenty bits were clocked before chip select rose.
	// Core reset clears the toggle so both sides of the crossing start equal.
	always_ff @(posedge chip_select_low or posedge rst) begin
		if (rst) begin
			frame_q     <= 20'h00000;
			frame_tog_q <= 1'b0;
		end else if (bcnt_q == 5'd20) begin
			frame_q     <= shin_q;
			frame_tog_q <= ~frame_tog_q;
		end
	end

	// Core domain.
	logic        tog_s1_q, tog_s2_q, tog_s3_q;
	logic [19:0] cmd_q, cmd_d;
	logic        cmd_new_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
			tog_s3_q <= 1'b0;
		end else begin
			tog_s1_q <= frame_tog_q;
			tog_s2_q <= tog_s1_q;
			tog_s3_q <= tog_s2_q;
		end
	end

	mode_t mode_q, mode_d;
	coil_t serial_coil_q, serial_coil_d;
	always_comb begin
		cmd_new_q     = tog_s2_q ^ tog_s3_q;
		cmd_d         = frame_q;
		mode_d        = mode_q;
		serial_coil_d = serial_coil_q;
		if (cmd_new_q) begin
			unique case (cmd_d[`CMD_SEL_MSB:`CMD_SEL_LSB])
				`CMD_COIL_A: serial_coil_d.coil_a = cmd_d[`COIL_MSB:0];
				`CMD_COIL_B: serial_coil_d.coil_b = cmd_d[`COIL_MSB:0];
				`CMD_MODE:   mode_d = cmd_d[7:0];
				`CMD_RSVD:   mode_d = mode_q;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_q        <= `MODE_RESET;
			serial_coil_q <= '0;
			cmd_q         <= 20'h00000;
		end else begin
			mode_q        <= mode_d;
			serial_coil_q <= serial_coil_d;
			cmd_q         <= cmd_d;
		end
	end

	// Pin inputs: two flip-flops, then a run-length glitch filter.
	logic [1:0] step_sy_q, dir_sy_q;
	logic       step_f_q, step_f_d, dir_f_q, dir_f_d;
	logic [7:0] step_run_q, step_run_d, dir_run_q, dir_run_d;
	always_comb begin
		step_f_d   = step_f_q;
		dir_f_d    = dir_f_q;
		step_run_d = 8'h00;
		dir_run_d  = 8'h00;
		if (step_sy_q[1] != step_f_q) begin
			step_run_d = step_run_q + 8'h01;
			if (step_run_d >= 8'(GLITCH_CYC)) begin
				step_f_d   = step_sy_q[1];
				step_run_d = 8'h00;
			end
		end
		if (dir_sy_q[1] != dir_f_q) begin
			dir_run_d = dir_run_q + 8'h01;
			if (dir_run_d >= 8'(GLITCH_CYC)) begin
				dir_f_d   = dir_sy_q[1];
				dir_run_d = 8'h00;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			step_sy_q  <= 2'h0;
			dir_sy_q   <= 2'h0;
			step_f_q   <= 1'b0;
			dir_f_q    <= 1'b0;
			step_run_q <= 8'h00;
			dir_run_q  <= 8'h00;
		end else begin
			step_sy_q  <= {step_sy_q[0], step_in};
			dir_sy_q   <= {dir_sy_q[0], dir_in};
			step_f_q   <= step_f_d;
			dir_f_q    <= dir_f_d;
			step_run_q <= step_run_d;
			dir_run_q  <= dir_run_d;
		end
	end

	// Microstep counter: 1024 entries per electrical period, so it wraps naturally.
	logic       step_prev_q;
	logic       step_act;
	logic [9:0] pos_q, pos_d;
	logic [9:0] inc;
	always_comb begin
		step_act = mode_q.dual_edge ? (step_f_q != step_prev_q)
		                            : (step_f_q & ~step_prev_q);
		// Resolution code 0 is 256 microsteps, 8 is full step, giving 1 to 256 counts.
		inc   = (mode_q.mres > 4'd8) ? 10'd256 : 10'(10'd1 << mode_q.mres);
		pos_d = pos_q;
		if (step_act && !mode_q.step_serial) begin
			pos_d = dir_f_q ? pos_q - inc : pos_q + inc;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			step_prev_q <= 1'b0;
			pos_q       <= 10'h000;
		end else begin
			step_prev_q <= step_f_q;
			pos_q       <= pos_d;
		end
	end

	// Quarter-wave sine, 257 entries, filled by an initial block at time zero; amplitude 248.
	function automatic logic [7:0] sine_q(input logic [7:0] idx);
		real x;
		x = $sin(3.14159265358979 * real'(idx) / 512.0) * 248.0;
		return 8'(int'(x));
	endfunction

	logic [7:0] sin_rom [0:256];
	initial begin
		for (int i = 0; i < 256; i++) begin
			sin_rom[i] = sine_q(8'(i));
		end
		sin_rom[256] = 8'hf8;
	end

	function automatic logic signed [8:0] wave(input logic [9:0] p);
		logic [8:0] q;
		logic [7:0] m;
		q = {1'b0, p[7:0]};
		m = p[8] ? sin_rom[9'd256 - q] : sin_rom[q];
		return p[9] ? -$signed({1'b0, m}) : $signed({1'b0, m});
	endfunction

	coil_t coil_d, coil_q;
	logic  on_d, on_q;
	logic [1:0] en_sy_q;
	always_comb begin
		coil_d.coil_a = wave(pos_q);
		coil_d.coil_b = wave(pos_q + 10'd256);
		if (mode_q.step_serial) begin
			coil_d = serial_coil_q;
		end
		on_d = ~en_sy_q[1] & mode_q.drive_ready;
		if (!on_d) begin
			coil_d = '0;
		end
	end

	// The enable pin is synchronised like the others; the analog stage also gates on it.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			coil_q  <= '0;
			on_q    <= 1'b0;
			en_sy_q <= 2'h3;
		end else begin
			coil_q  <= coil_d;
			on_q    <= on_d;
			en_sy_q <= {en_sy_q[0], output_stage_enable_low};
		end
	end

	always_comb begin
		coil_target = coil_q;
		bridge_on   = on_q;
		chop_hyst   = mode_q.chop_hyst;
		ustep_pos   = pos_q;
		status_word = {2'h0, on_q, mode_q.step_serial, mode_q.dual_edge, mode_q.chop_hyst, 4'h0, pos_q};
	end
endmodule
`default_nettype wire

// ==== include/stepper_cfg.svh ====
// Constants for the stepper front end: frame layout, field positions, timing.
// Assumes inclusion by bare name from the package and the design file.
`ifndef STEPPER_CFG_SVH
`define STEPPER_CFG_SVH
`define FRAME_BITS        20
`define CMD_SEL_MSB       19
`define CMD_SEL_LSB       18
`define CMD_COIL_A        2'h0
`define CMD_COIL_B        2'h1
`define CMD_MODE          2'h2
`define CMD_RSVD          2'h3
`define MODE_MRES_LSB     0
`define MODE_MRES_MSB     3
`define MODE_DUAL_EDGE_STEP_SELECT_BIT    4
`define MODE_SDOFF_BIT    5
`define MODE_CHOP_BIT     6
`define MODE_DRV_BIT      7
`define COIL_MSB          8
`define MODE_RESET        8'h00
`define GLITCH_NS         60
`define CLK_PERIOD_NS     8
`define GLITCH_CYCLES     ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define USTEP_BITS        10
`endif

// ==== include/stepper_pkg.sv ====
// Types shared by the stepper front end.
// Assumes the constants header is on the include path.
`include "stepper_cfg.svh"
package stepper_pkg;
	typedef struct packed {
		logic       drive_ready;
		logic       chop_hyst;
		logic       step_serial;
		logic       dual_edge;
		logic [3:0] mres;
	} mode_t;
	typedef struct packed {
		logic signed [8:0] coil_a;
		logic signed [8:0] coil_b;
	} coil_t;
endpackage

// ==== bench/stepper_front_properties.sv ====
// Checker for the stepper front end, watching only its ports.
// Assumes the bind below attaches it to every front end instance.
`timescale 1ns/1ns
`default_nettype none
module stepper_front_checker
	import stepper_pkg::*;
#(
	parameter int GLITCH_CYC = 8
) (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       bus_clk,
	input wire logic       chip_select_low,
	input wire logic       sdo,
	input wire logic       step_in,
	input wire logic       dir_in,
	input wire logic       output_stage_enable_low,
	input wire logic       bridge_on,
	input wire logic       chop_hyst,
	input wire coil_t      coil_target,
	input wire logic [9:0] ustep_pos
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Counts calm cycles on the pins; the margin covers filter, synchroniser and register.
	logic [5:0] quiet_q;
	always_ff @(posedge core_clk) begin
		if (rst || !chip_select_low || $changed(step_in) || $changed(dir_in)
			|| $changed(output_stage_enable_low)) begin
			quiet_q <= 6'h00;
		end else if (quiet_q != 6'h3f) begin
			quiet_q <= quiet_q + 6'h01;
		end
	end
	bridge_off_a: assert property (output_stage_enable_low [*4] |-> !bridge_on)
		else $error("bridge on while stage disabled");
	step_size_a: assert property (!$stable(ustep_pos) |-> $onehot(10'(ustep_pos - $past(ustep_pos)))
		|| $onehot(10'($past(ustep_pos) - ustep_pos))) else $error("bad step size");
	sdo_hold_a: assert property (!bus_clk && $past(!bus_clk) && !chip_select_low
		&& $past(!chip_select_low) |-> $stable(sdo)) else $error("sdo moved with bus clock low");
	pos_quiet_a: assert property (int'(quiet_q) > GLITCH_CYC + 12 |-> $stable(ustep_pos))
		else $error("position moved without step");
	coil_quiet_a: assert property (int'(quiet_q) > GLITCH_CYC + 12 |-> $stable(coil_target))
		else $error("coil moved without cause");
	mode_quiet_a: assert property (int'(quiet_q) > GLITCH_CYC + 12 |-> $stable(chop_hyst))
		else $error("chopper mode moved without frame");
	single_update_a: assert property ($changed(ustep_pos) |=> $stable(ustep_pos) [*4])
		else $error("one edge gave two updates");
	reset_state_a: assert property ($fell(rst) |-> ustep_pos == 10'h000 && !bridge_on && coil_target == '0)
		else $error("bad state after reset");
endmodule
bind stepper_front stepper_front_checker #(.GLITCH_CYC(GLITCH_CYC)) chk (.core_clk(core_clk), .rst(rst),
	.bus_clk(bus_clk), .chip_select_low(chip_select_low), .sdo(sdo), .step_in(step_in), .dir_in(dir_in),
	.output_stage_enable_low(output_stage_enable_low), .bridge_on(bridge_on), .chop_hyst(chop_hyst),
	.coil_target(coil_target), .ustep_pos(ustep_pos));
`default_nettype wire

// ==== bench/motion_ctrl_model.sv ====
// Motion controller model driving the serial port and the step and direction pins.
// Assumes the bench calls its tasks at a falling core clock edge.
`timescale 1ns/1ns
`default_nettype none
module motion_ctrl_model (
	output logic      bus_clk,
	output logic      chip_select_low,
	output logic      sdi,
	input  wire logic sdo,
	output logic      step_in,
	output logic      dir_in
);
	initial begin
		bus_clk = 1'b0;
		chip_select_low = 1'b1;
		sdi = 1'b0;
		step_in = 1'b0;
		dir_in = 1'b0;
	end
	// The bus clock stands low between frames; a short count is sent only to test refusal.
	task automatic frame(input int n, input logic [19:0] cmd, output logic [19:0] st);
		chip_select_low = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi = cmd[19 - i];
			#24 st = {st[18:0], sdo};
			bus_clk = 1'b1;
			#24 bus_clk = 1'b0;
		end
		#24 chip_select_low = 1'b1;
		sdi = ~sdi;
		#96;
	endtask
	task automatic pulse(input logic dir, input int hi);
		dir_in = dir;
		#104 step_in = 1'b1;
		#(hi) step_in = 1'b0;
		#200;
	endtask
endmodule
`default_nettype wire

// ==== bench/tb_stepper_front.sv ====
// Bench for the stepper front end: one task per scenario, judged at the ports.
// Assumes the front end, its package, the checker and the controller model are compiled.
`timescale 1ns/1ns
`default_nettype none
module tb_stepper_front;
	import stepper_pkg::*;
	logic core_clk, rst, enable_low;
	wire logic bus_clk, chip_select_low, sdi, sdo, step_in, dir_in, bridge_on, chop_hyst;
	coil_t coil_target;
	logic [9:0] ustep_pos, exp_pos;
	logic [19:0] st;
	int fail_count, total_checks;
	stepper_front DUT (.core_clk(core_clk), .rst(rst), .bus_clk(bus_clk), .chip_select_low(chip_select_low),
		.sdi(sdi), .sdo(sdo), .step_in(step_in), .dir_in(dir_in), .output_stage_enable_low(enable_low),
		.coil_target(coil_target), .bridge_on(bridge_on), .chop_hyst(chop_hyst), .ustep_pos(ustep_pos));
	motion_ctrl_model ctrl (.bus_clk(bus_clk), .chip_select_low(chip_select_low), .sdi(sdi), .sdo(sdo),
		.step_in(step_in), .dir_in(dir_in));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic set_mode(input logic [7:0] m);
		ctrl.frame(20, {2'h2, 10'h000, m}, st);
	endtask
	task automatic status(input logic [7:0] m, input logic br);
		ctrl.frame(20, 20'hc0000, st);
		check(st, {2'h0, br, m[5], m[4], m[6], 4'h0, exp_pos});
	endtask
	task automatic step(input logic d, input int inc);
		ctrl.pulse(d, 128);
		exp_pos = d ? exp_pos - 10'(inc) : exp_pos + 10'(inc);
		check(20'(ustep_pos), 20'(exp_pos));
	endtask
	task automatic t_reset();
		check({bridge_on, chop_hyst, 8'h00, ustep_pos}, 20'h00000);
		status(8'h00, 1'b0);
		step(1'b0, 1);
	endtask
	task automatic t_res();
		for (int k = 0; k <= 8; k++) begin
			set_mode(8'(k));
			step(1'b0, 1 << k);
		end
		repeat (3) step(1'b1, 256);
	endtask
	task automatic t_glitch();
		ctrl.pulse(1'b0, 40);
		check(20'(ustep_pos), 20'(exp_pos));
	endtask
	task automatic t_dual();
		set_mode(8'h18);
		step(1'b0, 512);
	endtask
	task automatic t_drive();
		@(negedge core_clk);
		enable_low = 1'b0;
		set_mode(8'hc0);
		status(8'hc0, 1'b1);
		check({18'h00000, bridge_on, chop_hyst}, 20'h00003);
		@(negedge core_clk);
		enable_low = 1'b1;
		repeat (8) @(negedge core_clk);
		check({19'h00000, bridge_on}, 20'h00000);
		set_mode(8'h80);
		ctrl.frame(19, {2'h2, 10'h000, 8'hc0}, st);
		check({19'h00000, chop_hyst}, 20'h00000);
	endtask
	task automatic t_serial();
		@(negedge core_clk);
		enable_low = 1'b0;
		set_mode(8'ha0);
		ctrl.frame(20, {2'h0, 9'h000, 9'h0a5}, st);
		ctrl.frame(20, {2'h1, 9'h000, 9'h15a}, st);
		check(20'(coil_target), {2'h0, 9'h0a5, 9'h15a});
		ctrl.pulse(1'b0, 128);
		check(20'(ustep_pos), 20'(exp_pos));
	endtask
	initial begin
		fail_count = 0;
		total_checks = 0;
		exp_pos = 10'h000;
		rst = 1'b1;
		enable_low = 1'b1;
		repeat (5) @(negedge core_clk);
		rst = 1'b0;
		t_reset();
		t_res();
		t_glitch();
		t_dual();
		t_drive();
		t_serial();
		summarize();
	end
	initial begin
		#500000;
		fail_count++;
		summarize();
	end
endmodule
`default_nettype wire
